// File: hw/port_regs_pkg.sv
// Register map, field masks and reset values of the port block
`default_nettype none
package port_regs_pkg;

   // Port slots: analog, third, fourth, twelfth, output-only
   localparam int NUM_DATA_PORTS = 5;
   localparam int NUM_IO_PORTS   = 4;
   localparam int SLOT_ANALOG    = 0;
   localparam int SLOT_THIRD     = 1;
   localparam int SLOT_FOURTH    = 2;
   localparam int SLOT_TWELFTH   = 3;
   localparam int SLOT_OUT_ONLY  = 4;

   // Data register byte addresses
   localparam logic [15:0] DATA_ADDR [0:NUM_DATA_PORTS-1] =
      '{16'hFF02, 16'hFF03, 16'hFF04, 16'hFF0C, 16'hFF0D};
   // Direction register byte addresses
   localparam logic [15:0] DIR_ADDR [0:NUM_IO_PORTS-1] =
      '{16'hFF22, 16'hFF23, 16'hFF24, 16'hFF2C};
   // Pull-up enable register byte addresses
   localparam logic [15:0] PU_ADDR [0:NUM_IO_PORTS-1] =
      '{16'hFF32, 16'hFF33, 16'hFF34, 16'hFF3C};
   // Analog function select register
   localparam logic [15:0] AFS_ADDR = 16'hFF84;

   // Implemented output latch bits per port
   localparam logic [7:0] LATCH_MASK [0:NUM_DATA_PORTS-1] =
      '{8'h0F, 8'h03, 8'h3F, 8'h0E, 8'h01};
   // Read-only reset-shared input bit of the third port
   localparam int          RESET_SHARED_BIT = 4;
   // Implemented direction bits; others read as one
   localparam logic [7:0] DIR_MASK [0:NUM_IO_PORTS-1] =
      '{8'h0F, 8'h03, 8'h3F, 8'h0E};
   // Implemented pull-up enable bits
   localparam logic [7:0] PU_MASK [0:NUM_IO_PORTS-1] =
      '{8'h0F, 8'h03, 8'h3F, 8'h08};
   localparam logic [7:0] AFS_MASK = 8'h0F;

   // Reset values
   localparam logic [7:0] LATCH_RESET = 8'h00;
   localparam logic [7:0] DIR_RESET   = 8'hFF;
   localparam logic [7:0] PU_RESET    = 8'h00;
   localparam logic [7:0] AFS_RESET   = 8'h00;

   // Alternate output pin positions
   localparam int TIMER_A_BIT = 1;
   localparam int TIMER_B_BIT = 2;
   localparam int SERIAL_BIT  = 3;

endpackage
`default_nettype wire

// File: hw/pin_sync.sv
// Three-stage input synchroniser with agreement filter per bit
`default_nettype none
module pin_sync #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rstn,
   // Asynchronous pin levels in, filtered levels out
   input  wire logic [WIDTH-1:0] pinIn,
   output var  logic [WIDTH-1:0] level
);

   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;

   // Shift chain; first stage is read only by the second
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         stage1 <= '0;
         stage2 <= '0;
         stage3 <= '0;
      end
      else
      begin
         stage1 <= pinIn;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   // A bit changes only once stages two and three agree
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         level <= '0;
      else
      begin
         for (int i = 0; i < WIDTH; i++)
         begin
            if (stage2[i] == stage3[i])
               level[i] <= stage3[i];
         end
      end
   end

endmodule
`default_nettype wire

// File: hw/port_data_pullup_altfunc.sv
// Port latches, direction, pull-up and analog select with pin drive
`default_nettype none
// Contract
// [R1] Data read: pin if input, latch if output
// [R2] Reset clears all data latches
// [R3] Latch 0/1 drives low/high in output
// [R4] Reset-shared bit is read-only, no latch
// [R5] Select bit routes pin to converter
// [R6] Reset clears analog select register
// [R7] Pull-up bit one connects pull-up
// [R8] Reset clears all pull-up enables
// [R9] Pull-ups only on documented pins
// [R10] Bit operations are whole-port read-modify-write
// [R11] Software sets direction/latch for alternate functions
// [R12] Unimplemented data bits read zero, ignore writes
// [R13] Direction 0 output, 1 input, reset ones
// [R14] Input-mode write updates latch, not pin
// [R15] Pull-up only while pin is input
// [R16] Alternate output combines peripheral and latch
// [R17] Writes take effect at next edge
module port_data_pullup_altfunc (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rstn,
   // CPU register port
   input  wire logic [15:0] regAddr,
   input  wire logic        regWrEn,
   input  wire logic [7:0]  regWrData,
   input  wire logic        regRdEn,
   output var  logic [7:0]  regRdData,
   // CPU single-bit manipulation at regAddr
   input  wire logic        bitOpEn,
   input  wire logic [2:0]  bitSel,
   input  wire logic        bitVal,
   // Pins, eight bits per port slot, slot 0 lowest
   input  wire logic [31:0] portPinIn,
   input  wire logic        resetSharedPinIn,
   output var  logic [39:0] portPinOut,
   output var  logic [39:0] portPinOeN,
   output var  logic [31:0] pullupOn,
   // Peripheral outputs and their enables
   input  wire logic        timerOutputA,
   input  wire logic        timerOutputAEn,
   input  wire logic        timerOutputB,
   input  wire logic        timerOutputBEn,
   input  wire logic        serialTransmit,
   input  wire logic        serialTransmitEn,
   // Filtered pin levels and converter routing for peripherals
   output var  logic [31:0] portLevel,
   output var  logic        resetSharedInputBit,
   output var  logic [3:0]  analogInputs
);

   localparam int ND = port_regs_pkg::NUM_DATA_PORTS;
   localparam int NI = port_regs_pkg::NUM_IO_PORTS;

   logic [7:0]  latch [0:ND-1];
   logic [7:0]  dir   [0:NI-1];
   logic [7:0]  pu    [0:NI-1];
   logic [7:0]  afs;
   logic [7:0]  next_latch [0:ND-1];
   logic [7:0]  next_dir   [0:NI-1];
   logic [7:0]  next_pu    [0:NI-1];
   logic [7:0]  next_afs;
   logic [32:0] syncLevel;
   logic [7:0]  readValue;
   logic [7:0]  writeValue;
   logic        writeEn;
   logic [39:0] next_pinOut;
   logic [39:0] next_pinOeN;
   logic [31:0] next_pullup;

   // Filtered pin levels, reset-shared pin on top
   pin_sync #(
      .WIDTH (33)
   ) u_sync (
      .clk   (clk),
      .rstn  (rstn),
      .pinIn ({resetSharedPinIn, portPinIn}),
      .level (syncLevel)
   );

   // Readback of the addressed register; unmapped reads zero
   always_comb
   begin
      readValue = 8'h00;
      for (int p = 0; p < ND; p++)
      begin
         if (regAddr == port_regs_pkg::DATA_ADDR[p])
         begin
            if (p < NI)
               readValue = ((dir[p] & syncLevel[p*8 +: 8])
                           | (~dir[p] & latch[p]))
                           & port_regs_pkg::LATCH_MASK[p]; // [R1] [R12]
            else
               readValue = latch[p] & port_regs_pkg::LATCH_MASK[p];
            if (p == port_regs_pkg::SLOT_THIRD)
               readValue[port_regs_pkg::RESET_SHARED_BIT] =
                  syncLevel[32]; // [R4]
         end
      end
      for (int p = 0; p < NI; p++)
      begin
         if (regAddr == port_regs_pkg::DIR_ADDR[p])
            readValue = dir[p];
         if (regAddr == port_regs_pkg::PU_ADDR[p])
            readValue = pu[p];
      end
      if (regAddr == port_regs_pkg::AFS_ADDR)
         readValue = afs;
   end

   // Byte write or whole-port read-modify-write for a bit operation
   always_comb
   begin
      writeValue = regWrData;
      writeEn    = regWrEn | bitOpEn;
      if (!regWrEn && bitOpEn)
      begin
         writeValue = readValue; // [R10]
         writeValue[bitSel] = bitVal;
      end
   end

   // Next register contents
   always_comb
   begin
      for (int p = 0; p < ND; p++)
      begin
         next_latch[p] = latch[p];
         if (writeEn && regAddr == port_regs_pkg::DATA_ADDR[p])
            next_latch[p] = writeValue
                            & port_regs_pkg::LATCH_MASK[p]; // [R12] [R14]
      end
      for (int p = 0; p < NI; p++)
      begin
         next_dir[p] = dir[p];
         next_pu[p]  = pu[p];
         if (writeEn && regAddr == port_regs_pkg::DIR_ADDR[p])
            next_dir[p] = writeValue | ~port_regs_pkg::DIR_MASK[p]; // [R13]
         if (writeEn && regAddr == port_regs_pkg::PU_ADDR[p])
            next_pu[p] = writeValue & port_regs_pkg::PU_MASK[p]; // [R9]
      end
      next_afs = afs;
      if (writeEn && regAddr == port_regs_pkg::AFS_ADDR)
         next_afs = writeValue & port_regs_pkg::AFS_MASK; // [R5]
   end

   // Register storage: a latch per port slot, direction and pull-up per I/O port slot
   genvar g;
   generate
      for (g = 0; g < ND; g++)
      begin : gLatch
         always_ff @(posedge clk or negedge rstn)
         begin
            if (!rstn)
               latch[g] <= port_regs_pkg::LATCH_RESET; // [R2]
            else
               latch[g] <= next_latch[g]; // [R17]
         end
      end
      for (g = 0; g < NI; g++)
      begin : gCtrl
         always_ff @(posedge clk or negedge rstn)
         begin
            if (!rstn)
            begin
               dir[g] <= port_regs_pkg::DIR_RESET; // [R13]
               pu[g]  <= port_regs_pkg::PU_RESET; // [R8]
            end
            else
            begin
               dir[g] <= next_dir[g];
               pu[g]  <= next_pu[g];
            end
         end
      end
   endgenerate

   // Analog function select register
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         afs <= port_regs_pkg::AFS_RESET; // [R6]
      else
         afs <= next_afs;
   end

   // Pin drive, enables and pull-ups from the next register state
   always_comb
   begin
      next_pinOut = '0;
      next_pinOeN = '1;
      next_pullup = '0;
      for (int p = 0; p < NI; p++)
      begin
         next_pinOut[p*8 +: 8] = next_latch[p]; // [R3]
         next_pinOeN[p*8 +: 8] =
            next_dir[p] | ~port_regs_pkg::LATCH_MASK[p]; // [R13] [R14]
         next_pullup[p*8 +: 8] = next_pu[p] & next_dir[p]; // [R7] [R15]
      end
      // Analog-selected pins never drive and take no pull-up
      next_pinOeN[3:0] = next_pinOeN[3:0] | next_afs[3:0]; // [R5]
      next_pullup[3:0] = next_pullup[3:0] & ~next_afs[3:0];
      // Output-only port always drives its one pin
      next_pinOut[39:32] = next_latch[port_regs_pkg::SLOT_OUT_ONLY];
      next_pinOeN[39:32] = ~port_regs_pkg::LATCH_MASK[
                              port_regs_pkg::SLOT_OUT_ONLY];
      // Timer outputs expect latch zero, serial output latch one
      if (timerOutputAEn)
         next_pinOut[8 + port_regs_pkg::TIMER_A_BIT] =
            timerOutputA
            | next_latch[1][port_regs_pkg::TIMER_A_BIT]; // [R16] [R11]
      if (timerOutputBEn)
         next_pinOut[16 + port_regs_pkg::TIMER_B_BIT] =
            timerOutputB
            | next_latch[2][port_regs_pkg::TIMER_B_BIT]; // [R16] [R11]
      if (serialTransmitEn)
         next_pinOut[16 + port_regs_pkg::SERIAL_BIT] =
            serialTransmit
            & next_latch[2][port_regs_pkg::SERIAL_BIT]; // [R16] [R11]
   end

   // Registered pin outputs
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         portPinOut <= '0;
         portPinOeN <= {8'hFE, 32'hFFFFFFFF}; // Output-only pin low
         pullupOn   <= '0;
      end
      else
      begin
         portPinOut <= next_pinOut; // [R17]
         portPinOeN <= next_pinOeN;
         pullupOn   <= next_pullup;
      end
   end

   // Registered read data
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         regRdData <= 8'h00;
      else if (regRdEn)
         regRdData <= readValue;
   end

   // Peripheral-facing levels and converter routing
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         portLevel           <= '0;
         resetSharedInputBit <= 1'b0;
         analogInputs        <= 4'h0;
      end
      else
      begin
         portLevel           <= syncLevel[31:0];
         resetSharedInputBit <= syncLevel[32];
         analogInputs        <= next_afs[3:0]; // [R5]
      end
   end

endmodule
`default_nettype wire

// File: test/port_asserts.sv
// Checker of the port block register and pin behaviour
`default_nettype none
module port_asserts (
   // Clock and reset
   input wire logic        clk,
   input wire logic        rstn,
   // Register port
   input wire logic [15:0] regAddr,
   input wire logic        regWrEn,
   input wire logic [7:0]  regWrData,
   input wire logic        regRdEn,
   input wire logic [7:0]  regRdData,
   // Pin side
   input wire logic [39:0] portPinOut,
   input wire logic [39:0] portPinOeN,
   input wire logic [31:0] pullupOn,
   input wire logic [3:0]  analogInputs
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   // Reset values seen at the first edge after release
   property p_rst_out;
      $rose(rstn) |-> portPinOut == 40'h00;
   endproperty
   a_rst_out: assert property (p_rst_out)
      else $error("reset drive");
   property p_rst_oe;
      $rose(rstn) |-> portPinOeN == 40'hFE_FFFF_FFFF;
   endproperty
   a_rst_oe: assert property (p_rst_oe)
      else $error("reset enable");
   property p_rst_pu;
      $rose(rstn) |-> pullupOn == 32'h0 && analogInputs == 4'h0;
   endproperty
   a_rst_pu: assert property (p_rst_pu)
      else $error("reset pull-up");
   // Register writes reach the pins one edge later
   property p_dir_wr; regWrEn && regAddr == 16'hFF24 |=>
      portPinOeN[21:16] == $past(regWrData[5:0]); endproperty
   a_dir_wr: assert property (p_dir_wr)
      else $error("direction");
   property p_lat_wr; regWrEn && regAddr == 16'hFF0D |=>
      portPinOut[32] == $past(regWrData[0]); endproperty
   a_lat_wr: assert property (p_lat_wr)
      else $error("latch drive");
   property p_afs_wr; regWrEn && regAddr == 16'hFF84 |=>
      analogInputs == $past(regWrData[3:0]); endproperty
   a_afs_wr: assert property (p_afs_wr)
      else $error("select");
   // Pull-ups only on input pins that have one
   property p_pu_in; (pullupOn & ~portPinOeN[31:0]) == 32'h0; endproperty
   a_pu_in: assert property (p_pu_in)
      else $error("pull-up driven");
   property p_pu_map; (pullupOn & ~32'h083F_030F) == 32'h0; endproperty
   a_pu_map: assert property (p_pu_map)
      else $error("pull-up map");
   // Read data
   property p_rd_lat; regRdEn && regAddr == 16'hFF0D |=>
      regRdData == {7'h00, $past(portPinOut[32])}; endproperty
   a_rd_lat: assert property (p_rd_lat)
      else $error("latch read");
   property p_rd_unimp; regRdEn && regAddr == 16'hFF04 |=>
      regRdData[7:6] == 2'h0; endproperty
   a_rd_unimp: assert property (p_rd_unimp)
      else $error("unused bits");
   // Main scenarios
   c_wr: cover property (regWrEn && regAddr == 16'hFF24);
   c_rd: cover property (regRdEn && regAddr == 16'hFF04);
   c_afs: cover property (analogInputs != 4'h0);
endmodule
bind port_data_pullup_altfunc port_asserts chk (.clk, .rstn, .regAddr,
   .regWrEn, .regWrData, .regRdEn, .regRdData, .portPinOut, .portPinOeN,
   .pullupOn, .analogInputs);
`default_nettype wire

// File: test/pin_model.sv
// Outside devices and pull-ups on the port pins
`default_nettype none
module pin_model (
   // Device pin drive
   input  wire logic [31:0] pinOut,
   input  wire logic [31:0] pinOeN,
   input  wire logic [31:0] pullupOn,
   // Level the outside device forces
   input  wire logic [31:0] ext,
   // Resolved pin level
   output var  logic [31:0] pinIn
);
   timeunit 1ns;
   timeprecision 1ps;
   // Driven pins follow the device, else pull-up, else outside level
   assign pinIn = (~pinOeN & pinOut) | (pinOeN & pullupOn)
      | (pinOeN & ~pullupOn & ext);
endmodule
`default_nettype wire

// File: test/tb.sv
// Self-checking bench of the port block
`default_nettype none
`define CHK(a, e) \
   begin \
      check_count++; \
      if ((a) !== (e)) \
      begin \
         fail_count++; \
         $display("ERROR %0t got %h exp %h", $time, a, e); \
      end \
   end
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {logic [15:0] a; logic [7:0] w; logic [7:0] r;} row_s;
   // Writes and the readback they should give
   row_s rows [12] = '{
      '{16'hFF22, 8'h05, 8'hF5}, '{16'hFF23, 8'h00, 8'hFC},
      '{16'hFF24, 8'h00, 8'hC0}, '{16'hFF2C, 8'h00, 8'hF1},
      '{16'hFF32, 8'hFF, 8'h0F}, '{16'hFF33, 8'hFF, 8'h03},
      '{16'hFF34, 8'hFF, 8'h3F}, '{16'hFF3C, 8'hFF, 8'h08},
      '{16'hFF84, 8'hFF, 8'h0F}, '{16'hFF0D, 8'hFF, 8'h01},
      '{16'hFF0C, 8'hFF, 8'h0E}, '{16'hFF00, 8'hFF, 8'h00}};
   logic        clk = 1'b0, rstn = 1'b0;
   logic [15:0] regAddr = 16'h0;
   logic [7:0]  regWrData = 8'h00, regRdData;
   logic        regWrEn = 1'b0, regRdEn = 1'b0, bitOpEn = 1'b0;
   logic [2:0]  bitSel = 3'h0;
   logic        bitVal = 1'b0, resetSharedPinIn = 1'b0;
   logic        timerOutputA = 1'b0, timerOutputAEn = 1'b0;
   logic        timerOutputB = 1'b0, timerOutputBEn = 1'b0;
   logic        serialTransmit = 1'b0, serialTransmitEn = 1'b0;
   logic [31:0] portPinIn, pullupOn, ext = 32'h0, portLevel;
   logic [39:0] portPinOut, portPinOeN;
   logic [3:0]  analogInputs;
   logic        resetSharedInputBit;
   int          fail_count = 0, check_count = 0, cycles = 0;
   // 125 MHz clock
   always #4 clk = ~clk;
   port_data_pullup_altfunc dut (.clk, .rstn, .regAddr, .regWrEn,
      .regWrData, .regRdEn, .regRdData, .bitOpEn, .bitSel, .bitVal,
      .portPinIn, .resetSharedPinIn, .portPinOut, .portPinOeN, .pullupOn,
      .timerOutputA, .timerOutputAEn, .timerOutputB,
      .timerOutputBEn, .serialTransmit, .serialTransmitEn,
      .portLevel, .resetSharedInputBit, .analogInputs);
   pin_model ext_dev (.pinOut(portPinOut[31:0]), .pinOeN(portPinOeN[31:0]),
      .pullupOn, .ext, .pinIn(portPinIn));
   task automatic wrap_up();
      $display("checks %0d errors %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // One byte write strobe
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(negedge clk);
      regAddr = a;
      regWrData = d;
      regWrEn = 1'b1;
      @(negedge clk);
      regWrEn = 1'b0;
   endtask
   // One read strobe, then compare
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      @(negedge clk);
      regAddr = a;
      regRdEn = 1'b1;
      @(negedge clk);
      regRdEn = 1'b0;
      `CHK(regRdData, e)
   endtask
   // Cut a hang short
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         fail_count++;
         wrap_up();
      end
   end
   initial
   begin
      repeat (16) @(negedge clk);
      rstn = 1'b1;
      foreach (rows[i])
      begin
         wr(rows[i].a, rows[i].w);
         rd(rows[i].a, rows[i].r);
      end
      // Mid-run reset restores defaults
      rstn = 1'b0;
      repeat (2) @(negedge clk);
      rstn = 1'b1;
      `CHK(pullupOn, 32'h0)
      `CHK(analogInputs, 4'h0)
      `CHK(portPinOeN, 40'hFE_FFFF_FFFF)
      rd(16'hFF84, 8'h00);
      rd(16'hFF34, 8'h00);
      rd(16'hFF24, 8'hFF);
      rd(16'hFF0D, 8'h00);
      // Input-mode write keeps the pin floating
      ext = 32'h0015_0000;
      wr(16'hFF04, 8'h2A);
      `CHK(portPinOeN[23:16], 8'hFF)
      repeat (8) @(negedge clk);
      rd(16'hFF04, 8'h15);
      `CHK(portLevel[23:16], 8'h15)
      // Low nibble to output, bits 4 and 5 stay inputs
      wr(16'hFF24, 8'h30);
      `CHK(portPinOut[19:16], 4'hA)
      `CHK(portPinOeN[19:16], 4'h0)
      rd(16'hFF04, 8'h1A);
      // Bit set rewrites input latches with pin levels
      @(negedge clk);
      regAddr = 16'hFF04;
      bitSel = 3'h0;
      bitVal = 1'b1;
      bitOpEn = 1'b1;
      @(negedge clk);
      bitOpEn = 1'b0;
      wr(16'hFF24, 8'h00);
      rd(16'hFF04, 8'h1B);
      // Peripheral outputs on the third and fourth ports
      timerOutputA = 1'b1;
      timerOutputAEn = 1'b1;
      timerOutputB = 1'b1;
      timerOutputBEn = 1'b1;
      serialTransmitEn = 1'b1;
      repeat (2) @(negedge clk);
      `CHK(portPinOut[19:18], 2'h1)
      `CHK(portPinOut[9], 1'b1)
      timerOutputAEn = 1'b0;
      timerOutputBEn = 1'b0;
      serialTransmitEn = 1'b0;
      // Enables off: pins fall back to the plain latch
      @(negedge clk);
      `CHK(portPinOut[19:18], 2'h2)
      `CHK(portPinOut[9], 1'b0)
      // Pull-ups reach only input pins
      wr(16'hFF24, 8'h30);
      ext = 32'h0;
      wr(16'hFF34, 8'hFF);
      `CHK(pullupOn[23:16], 8'h30)
      repeat (8) @(negedge clk);
      rd(16'hFF04, 8'h3B);
      `CHK(portLevel[23:16], 8'h3B)
      // Converter routing and the reset-shared input
      wr(16'hFF84, 8'h01);
      `CHK(analogInputs, 4'h1)
      resetSharedPinIn = 1'b1;
      wr(16'hFF03, 8'hFF);
      repeat (8) @(negedge clk);
      rd(16'hFF03, 8'h10);
      `CHK(resetSharedInputBit, 1'b1)
      wrap_up();
   end
endmodule
`default_nettype wire
